// ---- tjm_pkg.sv ----
package tjm_pkg;
    // ----------
    // frame layout
    // ----------
    localparam int POS_W       = 12;
    localparam int K_W         = 10;
    localparam int FRAME_BITS  = 2928;
    localparam int OVH_BITS    = 16;
    localparam int SLOT_COUNT  = 4;
    localparam int SLOT_BITS   = 728;
    localparam int C_COUNT     = 5;
    localparam int C_MAJ       = 3;
    localparam int C_BASE      = 100;
    localparam int C_STEP      = 120;
    localparam int J_IDX       = 600;
    localparam int TRIB_KBPS   = 34368;
    localparam int AGG_KBPS    = 139264;
    localparam int PPM_TOL     = 20;
    localparam logic [POS_W-1:0] FRAME_LAST = 12'(FRAME_BITS - 1);
    localparam logic [POS_W-1:0] OVH_POS    = 12'(OVH_BITS);
    localparam logic [K_W-1:0]   J_K        = 10'(J_IDX);
    localparam logic [2:0]       C_MAJ_W    = 3'(C_MAJ);

    // ----------
    // timing
    // ----------
    localparam int MCLK_HZ         = 10_000_000;
    localparam int AIS_TIME_US     = 900;
    localparam int AIS_CYCLES      = AIS_TIME_US * (MCLK_HZ / 1_000_000);
    localparam int RECOVERY_S      = 1;
    localparam int RECOVERY_CYCLES = RECOVERY_S * MCLK_HZ;

    // ----------
    // registers
    // ----------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_JUST   = 8'h08;
    localparam logic [7:0] REG_LEVEL  = 8'h0C;
    localparam int CTRL_SRC_ACT = 0;
    localparam int CTRL_SNK_ACT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int ST_TRAIL    = 0;
    localparam int ST_ALARM    = 1;
    localparam int ST_SETTLED  = 2;
    localparam int ST_SRC_SLIP = 3;
    localparam int ST_SNK_SLIP = 4;
    localparam int LVL_SNK_LSB = 8;

    // ----------
    // decoding
    // ----------
    function automatic logic tjm_is_cbit(input logic [K_W-1:0] k);
        logic hit;
        hit = 1'b0;
        for (int n = 0; n < C_COUNT; n++) begin
            if (int'(k) == C_BASE + n * C_STEP) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction
endpackage

// ---- tjm_estore.sv ----
`timescale 1ns/1ps
module tjm_estore #(
    parameter int AW = 5
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // store control
    input  wire logic        recenter,
    input  wire logic        wr_en,
    input  wire logic        wr_bit,
    input  wire logic        rd_en,
    // store state
    output logic             head_bit,
    output logic [AW:0]      level,
    output logic             slip
);
    import tjm_pkg::*;

    localparam int N = 1 << AW;
    localparam logic [AW:0]   LVL_FULL = (AW+1)'(N);
    localparam logic [AW:0]   LVL_MID  = (AW+1)'(N / 2);
    localparam logic [AW-1:0] PTR_MID  = AW'(N / 2);

    logic [N-1:0]  mem_r;
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   lvl_r;
    logic          slip_r;

    wire          overrun  = wr_en & ~rd_en & (lvl_r == LVL_FULL);
    wire          underrun = rd_en & ~wr_en & (lvl_r == '0);
    wire          resync   = recenter | overrun | underrun;
    wire [AW-1:0] wp_nxt   = wr_en ? wp_r + 1'b1 : wp_r;
    wire [AW-1:0] rp_nxt   = rd_en ? rp_r + 1'b1 : rp_r;
    wire [AW:0]   lvl_nxt  = (wr_en & ~rd_en) ? lvl_r + 1'b1 :
                             (rd_en & ~wr_en) ? lvl_r - 1'b1 : lvl_r;

    // a slip re-centres at once: one burst of errors beats a stuck store
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mem_r  <= '0;
            wp_r   <= PTR_MID;
            rp_r   <= '0;
            lvl_r  <= LVL_MID;
            slip_r <= 1'b0;
        end else begin
            if (wr_en) begin
                mem_r[wp_r] <= wr_bit;
            end
            wp_r   <= wp_nxt;
            slip_r <= overrun | underrun;
            rp_r   <= resync ? wp_nxt - PTR_MID : rp_nxt;
            lvl_r  <= resync ? LVL_MID : lvl_nxt;
        end
    end

    assign head_bit = mem_r[rp_r];
    assign level    = lvl_r;
    assign slip     = slip_r;
endmodule // tjm_estore

// ---- tjm_mux.sv ----
// Notes on behaviour
// - map one tributary into chosen slot
// - source store written on tributary clock
// - source store read at slot payload times
// - justification skips one read, stuffs opportunity
// - control bits carry decision at fixed places
// - source error free within 20 ppm
// - slot index parameter from one to four
// - drive aggregate only while source active
// - majority of control bits decides opportunity
// - sink store written with gapped slot bits
// - sink read by smoothed level-steered strobe
// - inactive sink sends ones, hides sink status
// - trail fail forces ones and server fail
// - all-ones stream keeps the smoothed rate
// - sink settles within bounded recovery time
// - sink error free within 20 ppm
// - frame 2928 bits, 16 bit overhead
`timescale 1ns/1ps
module tjm_mux #(
    parameter int SLOT       = 1,
    parameter int SRC_AW     = 5,
    parameter int SNK_AW     = 5,
    parameter int NCO_W      = 16,
    parameter int NCO_STEP   = 4096,
    parameter int NCO_TRIM   = 64,
    parameter int ALARM_CYC  = tjm_pkg::AIS_CYCLES,
    parameter int SETTLE_CYC = tjm_pkg::RECOVERY_CYCLES
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // tributary input pins
    input  wire logic        trib_clk_in,
    input  wire logic        trib_data_in,
    // aggregate pins
    input  wire logic        aggregate_timing_clock,
    input  wire logic        aggregate_frame_start,
    input  wire logic        agg_data_in,
    output logic             agg_data_out,
    output logic             agg_data_oe,
    // trail state
    input  wire logic        trail_fail_in,
    output logic             server_fail_out,
    output logic             alarm_insert_action,
    // recovered tributary
    output logic             trib_clk_out,
    output logic             tributary_data_out
);
    import tjm_pkg::*;

    localparam logic [1:0] SLOT_SEL = 2'(SLOT - 1);
    localparam logic [SRC_AW:0] SRC_MID = (SRC_AW+1)'(1 << (SRC_AW - 1));
    localparam logic [SNK_AW:0] SNK_MID = (SNK_AW+1)'(1 << (SNK_AW - 1));
    localparam logic [NCO_W:0] STEP_NOM  = (NCO_W+1)'(NCO_STEP);
    localparam logic [NCO_W:0] STEP_FAST = (NCO_W+1)'(NCO_STEP + NCO_TRIM);
    localparam logic [NCO_W:0] STEP_SLOW = (NCO_W+1)'(NCO_STEP - NCO_TRIM);

    // ----------
    // pin synchronisers
    // ----------
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic       tclk_d_r;
    logic       aclk_d_r;

    wire [5:0] pins_raw = {trib_clk_in, trib_data_in, aggregate_timing_clock,
                           aggregate_frame_start, agg_data_in, trail_fail_in};

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r  <= '0;
            sync2_r  <= '0;
            tclk_d_r <= 1'b0;
            aclk_d_r <= 1'b0;
        end else begin
            sync1_r  <= pins_raw;
            sync2_r  <= sync1_r;
            tclk_d_r <= sync2_r[5];
            aclk_d_r <= sync2_r[3];
        end
    end

    wire trib_tick = sync2_r[5] & ~tclk_d_r;
    wire trib_d_s  = sync2_r[4];
    wire agg_tick  = sync2_r[3] & ~aclk_d_r;
    wire fs_s      = sync2_r[2];
    wire agg_d_s   = sync2_r[1];
    wire trail_s   = sync2_r[0];

    // ----------
    // frame position
    // ----------
    logic [POS_W-1:0] pos_r;

    wire [POS_W-1:0] pos_inc = (pos_r == FRAME_LAST) ? '0 : pos_r + 1'b1;
    wire [POS_W-1:0] cur_pos = fs_s ? '0 : pos_inc;
    wire [POS_W-1:0] pay_pos = cur_pos - OVH_POS;
    wire             in_slot = (cur_pos >= OVH_POS) && (pay_pos[1:0] == SLOT_SEL);
    wire [K_W-1:0]   k_idx   = pay_pos[POS_W-1:2];
    wire             k0_bit  = in_slot && (k_idx == '0);
    wire             c_bit   = in_slot && tjm_is_cbit(k_idx);
    wire             j_bit   = in_slot && (k_idx == J_K);
    wire             d_bit   = in_slot && !c_bit && !j_bit;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pos_r <= FRAME_LAST;
        end else if (agg_tick) begin
            pos_r <= cur_pos;
        end
    end

    // ----------
    // control registers
    // ----------
    logic [1:0]  ctrl_r;
    logic [1:0]  sticky_r;
    logic [31:0] prdata_r;
    logic [15:0] just_cnt_r;
    logic [23:0] settle_r;

    wire src_act = ctrl_r[CTRL_SRC_ACT];
    wire snk_act = ctrl_r[CTRL_SNK_ACT];

    // ----------
    // source side
    // ----------
    logic             just_r;
    logic             out_r;
    logic             oe_r;
    logic             c_out_r;
    logic             j_out_r;
    logic             src_head;
    logic [SRC_AW:0]  src_lvl;
    logic             src_slip;

    // read only at slot payload times
    wire src_rd = src_act && agg_tick && (d_bit || (j_bit && !just_r));

    // store depth absorbs 20 ppm drift
    tjm_estore #(.AW(SRC_AW)) u_src_store (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .recenter (!src_act),
        .wr_en    (trib_tick),
        .wr_bit   (trib_d_s),
        .rd_en    (src_rd),
        .head_bit (src_head),
        .level    (src_lvl),
        .slip     (src_slip)
    );

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            just_r     <= 1'b0;
            just_cnt_r <= '0;
        // justify when the store runs low
        end else if (src_act && agg_tick && k0_bit) begin
            just_r     <= (src_lvl < SRC_MID);
            just_cnt_r <= just_cnt_r + 16'((src_lvl < SRC_MID) ? 1 : 0);
        end
    end

    // the point is shared; only the active source may drive
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            out_r   <= 1'b0;
            oe_r    <= 1'b0;
            c_out_r <= 1'b0;
            j_out_r <= 1'b0;
        end else if (!src_act) begin
            oe_r <= 1'b0;
        end else if (agg_tick) begin
            oe_r    <= in_slot;
            c_out_r <= c_bit;
            j_out_r <= j_bit;
            // slot payload bits from the store
            out_r   <= c_bit ? just_r : (j_bit && just_r) ? 1'b0 : src_head;
        end
    end

    assign agg_data_out = out_r;
    assign agg_data_oe  = oe_r;

    // ----------
    // sink side
    // ----------
    logic [2:0]       ones_r;
    logic [NCO_W-1:0] acc_r;
    logic             stb_r;
    logic             dout_r;
    logic             snk_head;
    logic [SNK_AW:0]  snk_lvl;
    logic             snk_slip;

    // majority of ones marks a stuff bit
    wire maj_stuff = (ones_r >= C_MAJ_W);
    wire snk_wr = snk_act && agg_tick && (d_bit || (j_bit && !maj_stuff));
    wire need_ones = !snk_act || trail_s;

    wire [NCO_W:0] step_w = (snk_lvl > SNK_MID) ? STEP_FAST :
                            (snk_lvl < SNK_MID) ? STEP_SLOW : STEP_NOM;
    wire [NCO_W:0] nco_sum = {1'b0, acc_r} + step_w;
    wire           nco_carry = nco_sum[NCO_W];

    // recentre while inactive and on slip
    // store depth absorbs 20 ppm drift
    tjm_estore #(.AW(SNK_AW)) u_snk_store (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .recenter (!snk_act),
        .wr_en    (snk_wr),
        .wr_bit   (agg_d_s),
        .rd_en    (nco_carry && snk_act),
        .head_bit (snk_head),
        .level    (snk_lvl),
        .slip     (snk_slip)
    );

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ones_r <= '0;
        end else if (agg_tick && k0_bit) begin
            ones_r <= '0;
        end else if (agg_tick && c_bit) begin
            ones_r <= ones_r + 3'(agg_d_s);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            acc_r  <= '0;
            stb_r  <= 1'b0;
            dout_r <= 1'b1;
        end else begin
            acc_r <= nco_sum[NCO_W-1:0];
            stb_r <= nco_carry;
            if (nco_carry) begin
                dout_r <= need_ones | snk_head;
            end
        end
    end

    assign trib_clk_out        = stb_r;
    assign tributary_data_out  = dout_r;
    assign server_fail_out     = trail_s;
    assign alarm_insert_action = trail_s;

    // recovery timer after the last slip
    wire settled = (int'(settle_r) >= SETTLE_CYC);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            settle_r <= '0;
        end else if (snk_slip || !snk_act) begin
            settle_r <= '0;
        end else if (!settled) begin
            settle_r <= settle_r + 1'b1;
        end
    end

    // ----------
    // apb slave
    // ----------
    wire apb_setup = psel && !penable;
    wire apb_acc   = psel && penable;
    wire hit       = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
                     (paddr == REG_JUST) || (paddr == REG_LEVEL);
    wire wr_ctrl   = apb_acc && pwrite && (paddr == REG_CTRL);
    wire wr_stat   = apb_acc && pwrite && (paddr == REG_STATUS);
    wire [1:0] clr = wr_stat ? {pwdata[ST_SNK_SLIP], pwdata[ST_SRC_SLIP]} : 2'h0;
    wire [1:0] sticky_nxt = (sticky_r & ~clr) | {snk_slip, src_slip};

    wire [31:0] stat_word = 32'({sticky_r[1] & snk_act, sticky_r[0],
                                 settled & snk_act, trail_s & snk_act,
                                 trail_s & snk_act});
    wire [31:0] lvl_word  = (32'(snk_lvl) << LVL_SNK_LSB) | 32'(src_lvl);
    wire [31:0] rd_word   = (paddr == REG_CTRL)   ? 32'(ctrl_r)     :
                            (paddr == REG_STATUS) ? stat_word       :
                            (paddr == REG_JUST)   ? 32'(just_cnt_r) :
                            (paddr == REG_LEVEL)  ? lvl_word        : 32'h0000_0000;

    // a new slip on the clearing edge survives the clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r   <= CTRL_RESET;
            sticky_r <= '0;
            prdata_r <= '0;
        end else begin
            sticky_r <= sticky_nxt;
            if (wr_ctrl) begin
                ctrl_r <= pwdata[1:0];
            end
            if (apb_setup) begin
                prdata_r <= rd_word;
            end
        end
    end

    assign prdata  = prdata_r;
    assign pready  = apb_acc;
    assign pslverr = apb_acc && !hit;

    // ----------
    // checks
    // ----------
    logic [15:0] ais_wait_r;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ais_wait_r <= '0;
        end else begin
            ais_wait_r <= (need_ones && !dout_r) ? ais_wait_r + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_jopp;
        agg_tick && j_bit;
    endsequence

    sequence s_src_stuff;
        s_jopp ##0 src_act && just_r;
    endsequence

    chk_slot_range: assert property (SLOT >= 1 && SLOT <= SLOT_COUNT)
        else $error("slot index out of range");
    chk_slot_bound: assert property (in_slot |-> int'(k_idx) < SLOT_BITS)
        else $error("slot bit beyond payload");
    chk_oe_active: assert property (!src_act |=> !agg_data_oe)
        else $error("aggregate driven while inactive");
    chk_read_slot: assert property (src_rd |-> in_slot && !c_bit)
        else $error("store read outside payload");
    chk_cbit_value: assert property (agg_data_oe && c_out_r |-> agg_data_out == just_r)
        else $error("control bit differs from decision");
    chk_stuff_skip: assert property (s_src_stuff |-> !src_rd ##1 !agg_data_out)
        else $error("justification did not skip a read");
    chk_jbit_data: assert property (s_jopp ##0 src_act && !just_r |-> src_rd)
        else $error("opportunity left empty without justification");
    chk_vote_write: assert property (s_jopp ##0 snk_act |-> snk_wr == (ones_r < C_MAJ_W))
        else $error("majority vote ignored");
    // ones at every strobe while inactive
    chk_idle_ones: assert property (!snk_act ##1 stb_r |-> tributary_data_out)
        else $error("inactive sink output not all ones");
    chk_alarm_bound: assert property (int'(ais_wait_r) < ALARM_CYC)
        else $error("all-ones not inserted in time");
    // store held at mid depth while inactive
    chk_recentre: assert property (!snk_act ##1 !snk_act |-> snk_lvl == SNK_MID)
        else $error("sink store not recentred");
endmodule // tjm_mux

// ---- tjm_far_model.sv ----
`timescale 1ns/1ps
// ----------
// far end: aggregate timing, one-frame loopback, slot check
// ----------
module tjm_far_model #(
    parameter int SLOT = 1
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // aggregate pins
    input  wire logic        agg_data_out,
    input  wire logic        agg_data_oe,
    output logic             aggregate_timing_clock,
    output logic             aggregate_frame_start,
    output logic             agg_data_in,
    // test control and results
    input  wire logic        chk_en,
    input  wire logic        c_flip,
    output logic [15:0]      err_cnt,
    output logic [15:0]      bit_cnt,
    output logic [15:0]      just_cnt
);
    import tjm_pkg::*;
    logic [1:0]  ph;
    logic [11:0] pos, pp;
    logic [2:0]  csum, hn;
    logic [6:0]  hist;
    logic        own, cb, dat, flip, b;
    int          p16, k;
    logic        mem [FRAME_BITS] = '{default: 1'b1};
    assign aggregate_timing_clock = !ph[1];
    assign aggregate_frame_start  = (pos == 12'h000);
    // the bit on the line now belongs to the previous position
    assign pp   = (pos == 12'h000) ? FRAME_LAST : pos - 12'h001;
    assign p16  = int'(pp) - OVH_BITS;
    assign k    = p16 / 4;
    assign own  = (pp >= OVH_POS) && (p16 % 4 + 1 == SLOT);
    assign cb   = k >= C_BASE && k <= C_BASE + 4 * C_STEP && (k - C_BASE) % C_STEP == 0;
    assign dat  = !cb && !(k == J_IDX && csum == 3'h5);
    assign flip = c_flip && own && (k == C_BASE || k == C_BASE + C_STEP);
    assign b    = agg_data_out;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ph <= 2'h0;
            pos <= 12'h000;
            agg_data_in <= 1'b1;
            csum <= 3'h0;
            hn <= 3'h0;
            hist <= 7'h00;
            err_cnt <= 16'h0000;
            bit_cnt <= 16'h0000;
            just_cnt <= 16'h0000;
        end else begin
            ph <= ph + 2'h1;
            if (ph == 2'h3) pos <= (pos == FRAME_LAST) ? 12'h000 : pos + 12'h001;
            if (ph == 2'h2) begin
                // next position's bit must stand before its clock edge
                agg_data_in <= mem[(pos == FRAME_LAST) ? 12'h000 : pos + 12'h001];
                // undriven bits toggle, two control bits bent
                mem[pp] <= (agg_data_oe ? b : pos[0]) ^ flip;
                if (agg_data_oe && !own) err_cnt <= err_cnt + 16'h0001;
                if (!chk_en) begin
                    hn <= 3'h0;
                    csum <= 3'h0;
                end else if (own && agg_data_oe) begin
                    if (cb) csum <= csum + {2'b00, b};
                    if (k == J_IDX) csum <= 3'h0;
                    if (k == J_IDX && csum != 3'h0 && csum != 3'h5) err_cnt <= err_cnt + 16'h0001;
                    if (k == J_IDX && csum == 3'h5) begin
                        just_cnt <= just_cnt + 16'h0001;
                        if (b) err_cnt <= err_cnt + 16'h0001;
                    end
                    if (dat) begin
                        if (hn == 3'h7 && b !== (hist[6] ^ hist[5])) err_cnt <= err_cnt + 16'h0001;
                        hist <= {hist[5:0], b};
                        if (hn != 3'h7) hn <= hn + 3'h1;
                        bit_cnt <= bit_cnt + 16'h0001;
                    end
                end
            end
        end
    end
endmodule // tjm_far_model

// ---- tjm_mux_tb.sv ----
`timescale 1ns/1ps
module tjm_mux_tb;
    import tjm_pkg::*;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        trib_clk_in = 1'b0;
    logic        trib_data_in = 1'b0;
    logic        trail_fail_in = 1'b0;
    logic        chk_en = 1'b0;
    logic        c_flip = 1'b0;
    logic [6:0]  prbs = 7'h7F;
    logic [31:0] prdata;
    logic [15:0] err_cnt, bit_cnt, just_cnt;
    logic        pready, pslverr, agg_data_out, agg_data_oe, server_fail_out;
    logic        aggregate_timing_clock, aggregate_frame_start, agg_data_in;
    logic        alarm_insert_action, trib_clk_out, tributary_data_out;
    int          tacc = 0;
    int          num_errors = 0;
    int          checked = 0;
    tjm_mux #(.SLOT(3), .ALARM_CYC(200), .SETTLE_CYC(500)) u_dut (
        .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trib_clk_in(trib_clk_in),
        .trib_data_in(trib_data_in), .aggregate_timing_clock(aggregate_timing_clock),
        .aggregate_frame_start(aggregate_frame_start), .agg_data_in(agg_data_in),
        .agg_data_out(agg_data_out), .agg_data_oe(agg_data_oe),
        .trail_fail_in(trail_fail_in), .server_fail_out(server_fail_out),
        .alarm_insert_action(alarm_insert_action), .trib_clk_out(trib_clk_out),
        .tributary_data_out(tributary_data_out));
    tjm_far_model #(.SLOT(3)) u_far (
        .mclk(mclk), .reset_n(reset_n), .agg_data_out(agg_data_out),
        .agg_data_oe(agg_data_oe), .aggregate_timing_clock(aggregate_timing_clock),
        .aggregate_frame_start(aggregate_frame_start), .agg_data_in(agg_data_in),
        .chk_en(chk_en), .c_flip(c_flip), .err_cnt(err_cnt), .bit_cnt(bit_cnt),
        .just_cnt(just_cnt));
    initial begin
        forever #50 mclk = ~mclk;
    end
    // ----------
    // tributary: sequence bits, one per 16.2125 clocks, between the slot limits
    // ----------
    always @(posedge mclk) begin
        tacc <= (tacc + 80) % 1297;
        if (tacc + 80 >= 1297) begin
            trib_clk_in <= 1'b0;
            trib_data_in <= prbs[6] ^ prbs[5];
            prbs <= {prbs[5:0], prbs[6] ^ prbs[5]};
        end else if (tacc >= 640 && tacc < 720) begin
            trib_clk_in <= 1'b1;
        end
    end
    task automatic complete_run();
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic give_up();
        num_errors++;
        complete_run();
    endtask
    task automatic chk(input logic ok, input string what);
        checked++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int t;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        for (t = 0; t < 50; t++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (t == 50) give_up();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_fs();
        int t;
        logic was;
        was = 1'b1;
        for (t = 0; t < 13000; t++) begin
            @(posedge mclk);
            if (aggregate_frame_start === 1'b1 && !was) break;
            was = aggregate_frame_start;
        end
        if (t == 13000) give_up();
    endtask
    // count output strobes; judge bits as ones or as the sequence
    task automatic watch(input int n, input logic ones, output int bits, output int bad);
        logic [6:0] h;
        h = 7'h00;
        bits = 0;
        bad = 0;
        repeat (n) begin
            @(posedge mclk);
            if (trib_clk_out === 1'b1) begin
                if (ones) bad += (tributary_data_out !== 1'b1);
                else if (bits >= 7) bad += (tributary_data_out !== (h[6] ^ h[5]));
                h = {h[5:0], tributary_data_out};
                bits++;
            end
        end
    endtask
    task automatic t_regs();
        logic [31:0] rd;
        logic er;
        apb(1'b0, REG_CTRL, 32'h0, rd, er);
        chk(rd[1:0] === CTRL_RESET, "control reset");
        apb(1'b1, REG_CTRL, 32'h0000_0003, rd, er);
        apb(1'b0, REG_CTRL, 32'h0, rd, er);
        chk(rd[1:0] === 2'h3 && er === 1'b0, "control readback");
        apb(1'b1, 8'h10, 32'hFFFF_FFFF, rd, er);
        chk(er === 1'b1, "unmapped write");
        apb(1'b0, 8'h10, 32'h0, rd, er);
        chk(er === 1'b1 && rd === 32'h0000_0000, "unmapped read");
    endtask
    task automatic t_source();
        logic [31:0] rd, j0, j1;
        logic er;
        int bits, bad;
        c_flip <= 1'b1;
        repeat (3) wait_fs();
        apb(1'b1, REG_STATUS, 32'h0000_0018, rd, er);
        wait_fs();
        chk_en <= 1'b1;
        apb(1'b0, REG_JUST, 32'h0, j0, er);
        watch(20000, 1'b0, bits, bad);
        wait_fs();
        apb(1'b0, REG_JUST, 32'h0, j1, er);
        chk(16'(j1 - j0) === just_cnt, "justification count");
        chk(err_cnt === 16'h0000, "slot content");
        chk(bit_cnt > 16'd1400, "slot data count");
        chk(bad == 0 && bits >= 1215 && bits <= 1250, "recovered stream");
        apb(1'b0, REG_STATUS, 32'h0, rd, er);
        chk(rd[ST_SETTLED] === 1'b1, "sink settled");
        chk(rd[ST_SRC_SLIP] === 1'b0 && rd[ST_SNK_SLIP] === 1'b0, "store slip");
    endtask
    task automatic t_alarm();
        logic [31:0] rd;
        logic er;
        int bits, bad;
        trail_fail_in <= 1'b1;
        repeat (5) @(posedge mclk);
        chk(server_fail_out === 1'b1 && alarm_insert_action === 1'b1, "flags set");
        watch(40, 1'b0, bits, bad);
        watch(1600, 1'b1, bits, bad);
        chk(bad == 0 && bits >= 96 && bits <= 102, "ones stream");
        apb(1'b0, REG_STATUS, 32'h0, rd, er);
        chk(rd[ST_TRAIL] === 1'b1 && rd[ST_ALARM] === 1'b1, "alarm status");
        trail_fail_in <= 1'b0;
        repeat (5) @(posedge mclk);
        chk(server_fail_out === 1'b0 && alarm_insert_action === 1'b0, "flags clear");
        watch(40, 1'b0, bits, bad);
        watch(1600, 1'b0, bits, bad);
        chk(bad == 0 && bits > 90, "data restored");
    endtask
    task automatic t_inactive();
        logic [31:0] rd;
        logic er;
        int bits, bad;
        apb(1'b1, REG_CTRL, 32'h0000_0001, rd, er);
        trail_fail_in <= 1'b1;
        repeat (8) @(posedge mclk);
        apb(1'b0, REG_STATUS, 32'h0, rd, er);
        chk(rd[2:0] === 3'h0 && rd[ST_SNK_SLIP] === 1'b0, "status hidden");
        watch(800, 1'b1, bits, bad);
        chk(bad == 0 && bits > 40, "inactive ones");
        apb(1'b0, REG_LEVEL, 32'h0, rd, er);
        chk(rd[15:8] === 8'h10, "sink store centred");
        apb(1'b1, REG_CTRL, 32'h0, rd, er);
        trail_fail_in <= 1'b0;
        repeat (2) @(posedge mclk);
        bad = 0;
        repeat (3000) begin
            @(posedge mclk);
            bad += (agg_data_oe !== 1'b0);
        end
        chk(bad == 0, "source silent");
        apb(1'b0, REG_LEVEL, 32'h0, rd, er);
        chk(rd[7:0] === 8'h10, "source store centred");
    endtask
    initial begin
        repeat (99000) @(posedge mclk);
        give_up();
    end
    initial begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        t_regs();
        t_source();
        t_alarm();
        t_inactive();
        complete_run();
    end
endmodule // tjm_mux_tb
